// *** hdl/nsb_ctrl.sv ***
// Normal-space external bus controller: APB registers, CPU / transfer
// controller arbitration, activation request ordering, and byte-wide
// SRAM-style cycles with waits and chip-select extension.
// Assumes requesters hold req until ack and run on pclk.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module nsb_ctrl
    import nsb_pkg::*;
#(
    parameter int NSRC = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_req,
    input wire nsb_req_t cpu_cmd,
    input wire logic cpu_int_io,
    output logic cpu_ack,
    output logic [31:0] cpu_rdata,
    input wire logic tc_req,
    input wire nsb_req_t tc_cmd,
    output logic tc_ack,
    output logic [31:0] tc_rdata,
    input wire logic [NSRC-1:0] act_req,
    input wire logic tc_active,
    input wire logic tc_ready,
    output logic act_start,
    output logic [$clog2(NSRC)-1:0] act_src,
    output logic info_skip_disable,
    output logic [31:0] ext_addr,
    output logic chip_select_n,
    output logic read_strobe_n,
    output logic low_write_strobe_n,
    output logic high_write_strobe_n,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic [7:0] data_in,
    input wire logic wait_n
);

    localparam int SW = $clog2(NSRC);

    function automatic logic [2:0] last_index(input logic [1:0] size);
        last_index = (size == NSB_SIZE_LONG) ? 3'h3 : (size == NSB_SIZE_WORD) ? 3'h1 : 3'h0;
    endfunction : last_index

    // Big-endian lane pick: byte 0 is the most significant of the datum
    function automatic logic [7:0] lane_of(input logic [31:0] d, input logic [1:0] size,
                                           input logic [1:0] idx);
        logic [1:0] sh;
        sh = 2'(last_index(size)) - idx;
        lane_of = d[{sh, 3'h0} +: 8];
    endfunction : lane_of

    // Registers
    logic [15:0] bus_function_extension;
    logic [12:0] space_wait_control;

    wire cpu_pri = bus_function_extension[NSB_BFE_CPU_PRI_BIT];
    wire order_fixed = bus_function_extension[NSB_BFE_ORDER_BIT];
    wire [3:0] rd_wait = space_wait_control[NSB_SWC_RD_WAIT_LSB +: 4];
    wire [3:0] wr_wait = space_wait_control[NSB_SWC_WR_WAIT_LSB +: 4];
    wire wait_mask = space_wait_control[NSB_SWC_WAIT_MASK_BIT];
    wire [1:0] setup_n = space_wait_control[NSB_SWC_SETUP_LSB +: 2];
    wire [1:0] hold_n = space_wait_control[NSB_SWC_HOLD_LSB +: 2];

    // Wait pin: three flops, level taken when the last two agree
    logic [2:0] wait_sync;
    logic wait_low;
    wire wait_agree = (wait_sync[1] == wait_sync[2]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_sync <= 3'h7;
            wait_low <= 1'b0;
        end else if (ce) begin
            wait_sync <= {wait_sync[1:0], wait_n};
            if (wait_agree) begin
                wait_low <= ~wait_sync[2];
            end
        end
    end

    // Pin is only honoured with the mask clear
    wire ext_hold = !wait_mask && wait_low;

    // Access state
    nsb_state_t state;
    nsb_state_t next_state;
    nsb_req_t cur;
    logic cur_tc;
    logic [1:0] byte_idx;
    logic [3:0] wcnt;
    logic [1:0] ph_cnt;
    logic [31:0] shift_in;
    logic io_flag;

    wire idle = (state == NSB_IDLE);
    wire cpu_go = cpu_req && !cpu_ack && (!(tc_req && !tc_ack) || cpu_pri); // Standing ack: request is stale
    wire tc_go = tc_req && !tc_ack && !cpu_go;
    wire grant = idle && (cpu_go || tc_go);
    nsb_req_t grant_cmd;
    assign grant_cmd = cpu_go ? cpu_cmd : tc_cmd;
    wire need_io_nop = cpu_go && io_flag && !cpu_pri;
    wire last_byte = ({1'b0, byte_idx} == last_index(cur.size));
    wire [3:0] sw_wait = cur.we ? wr_wait : rd_wait;
    wire leave_wait = (wcnt <= 4'h1) && !ext_hold;
    nsb_state_t start_state;
    assign start_state = (setup_n != 2'h0) ? NSB_SETUP : NSB_FIRST;
    wire byte_end = (state == NSB_FINAL && hold_n == 2'h0) || (state == NSB_HOLD && ph_cnt == 2'h0);
    wire access_done = byte_end && last_byte;
    wire byte_next = byte_end && !last_byte;

    always_comb begin
        next_state = state;
        unique case (state)
            NSB_IDLE: begin
                if (grant) begin
                    next_state = need_io_nop ? NSB_NOP : start_state;
                end
            end
            NSB_NOP: next_state = start_state;
            NSB_SETUP: begin
                if (ph_cnt == 2'h0) begin
                    next_state = NSB_FIRST;
                end
            end
            // First then final with no waits; wait state decided in first, ahead of final
            NSB_FIRST: next_state = (sw_wait != 4'h0 || ext_hold) ? NSB_WAIT : NSB_FINAL;
            NSB_WAIT: next_state = leave_wait ? NSB_FINAL : NSB_WAIT;
            NSB_FINAL: next_state = (hold_n != 2'h0) ? NSB_HOLD : NSB_IDLE;
            NSB_HOLD: next_state = (ph_cnt == 2'h0) ? NSB_IDLE : NSB_HOLD;
        endcase
        if (byte_next) begin
            next_state = wait_mask ? start_state : NSB_NOP;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= NSB_IDLE;
            cur <= '0;
            cur_tc <= 1'b0;
            byte_idx <= 2'h0;
            wcnt <= 4'h0;
            ph_cnt <= 2'h0;
            shift_in <= 32'h0;
        end else if (ce) begin
            state <= next_state;
            if (grant) begin
                cur <= grant_cmd;
                cur_tc <= !cpu_go;
                byte_idx <= 2'h0;
                shift_in <= 32'h0;
            end else if (byte_next) begin
                byte_idx <= byte_idx + 2'h1;
            end
            if (next_state == NSB_SETUP && state != NSB_SETUP) begin
                ph_cnt <= setup_n - 2'h1;
            end else if (next_state == NSB_HOLD && state != NSB_HOLD) begin
                ph_cnt <= hold_n - 2'h1;
            end else if (ph_cnt != 2'h0) begin
                ph_cnt <= ph_cnt - 2'h1;
            end
            if (state == NSB_FIRST) begin
                wcnt <= sw_wait;
            end else if (state == NSB_WAIT && wcnt != 4'h0) begin
                wcnt <= wcnt - 4'h1;
            end
            if (state == NSB_FINAL && !cur.we) begin
                shift_in <= {shift_in[23:0], data_in};
            end
        end
    end

    // Internal I/O marker: a fresh I/O access wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_flag <= 1'b0;
        end else if (ce) begin
            if (cpu_int_io) begin
                io_flag <= 1'b1;
            end else if (grant && cpu_go) begin
                io_flag <= 1'b0;
            end
        end
    end

    // External pins from flops, except the high write strobe, which is tied high
    wire in_cycle = !(next_state == NSB_IDLE || next_state == NSB_NOP);
    wire strobe_on = (next_state == NSB_FIRST || next_state == NSB_WAIT || next_state == NSB_FINAL);
    wire [1:0] next_idx = grant ? 2'h0 : byte_next ? byte_idx + 2'h1 : byte_idx;
    nsb_req_t next_cmd;
    assign next_cmd = grant ? grant_cmd : cur;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chip_select_n <= 1'b1;
            read_strobe_n <= 1'b1;
            low_write_strobe_n <= 1'b1;
            data_oe <= 1'b0;
            data_out <= 8'h00;
            ext_addr <= 32'h0;
        end else if (ce) begin
            chip_select_n <= !in_cycle;
            read_strobe_n <= !(strobe_on && !next_cmd.we);
            low_write_strobe_n <= !(strobe_on && next_cmd.we);
            data_oe <= in_cycle && next_cmd.we;
            if (in_cycle) begin
                ext_addr <= next_cmd.addr + {30'h0, next_idx};
                data_out <= lane_of(next_cmd.wdata, next_cmd.size, next_idx);
            end
        end
    end

    assign high_write_strobe_n = 1'b1;

    // Requester answers
    wire [31:0] final_rdata = cur.we ? 32'h0 :
                              (state == NSB_FINAL) ? {shift_in[23:0], data_in} : shift_in;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_ack <= 1'b0;
            tc_ack <= 1'b0;
            cpu_rdata <= 32'h0;
            tc_rdata <= 32'h0;
        end else if (ce) begin
            cpu_ack <= access_done && !cur_tc;
            tc_ack <= access_done && cur_tc;
            if (access_done && !cur_tc) begin
                cpu_rdata <= final_rdata;
            end
            if (access_done && cur_tc) begin
                tc_rdata <= final_rdata;
            end
        end
    end

    // Activation request ordering
    logic [NSRC-1:0] pending;
    logic [3:0] age [NSRC];
    logic [SW-1:0] pick_fixed;
    logic [SW-1:0] pick_old;

    always_comb begin
        pick_fixed = '0;
        pick_old = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                pick_fixed = SW'(i);
            end
        end
        for (int i = 0; i < NSRC; i++) begin
            if (pending[i] && (!pending[pick_old] || age[i] > age[pick_old])) begin
                pick_old = SW'(i);
            end
        end
    end

    wire use_fixed = order_fixed || tc_active;
    wire [SW-1:0] pick = use_fixed ? pick_fixed : pick_old;
    wire launch = tc_ready && (pending != '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= '0;
            act_start <= 1'b0;
            act_src <= '0;
            for (int i = 0; i < NSRC; i++) begin
                age[i] <= 4'h0;
            end
        end else if (ce) begin
            act_start <= launch;
            if (launch) begin
                act_src <= pick;
            end
            for (int i = 0; i < NSRC; i++) begin
                // A new request on the served source is kept
                if (act_req[i]) begin
                    pending[i] <= 1'b1;
                end else if (launch && pick == SW'(i)) begin
                    pending[i] <= 1'b0;
                end
                // Saturating age; ties after saturation fall to the lower index
                if (!pending[i] || (launch && pick == SW'(i))) begin
                    age[i] <= 4'h0;
                end else if (age[i] != NSB_AGE_MAX) begin
                    age[i] <= age[i] + 4'h1;
                end
            end
        end
    end

    assign info_skip_disable = order_fixed;

    // APB slave, zero wait states
    wire apb_wr = psel && penable && pwrite;
    wire hit_bfe = (paddr == NSB_OFS_BUS_FUNC_EXT);
    wire hit_swc = (paddr == NSB_OFS_SPACE_WAIT);
    wire hit_st = (paddr == NSB_OFS_STATUS);
    wire mapped = hit_bfe || hit_swc || hit_st;

    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0;
        status_word[NSB_ST_BUSY_BIT] = !idle;
        status_word[NSB_ST_TC_OWNER_BIT] = cur_tc;
        status_word[NSB_ST_STATE_LSB +: 3] = state;
        status_word[NSB_ST_PEND_LSB +: NSRC] = pending;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_function_extension <= NSB_BFE_RESET;
            space_wait_control <= NSB_SWC_RESET;
        end else if (ce && apb_wr) begin
            if (hit_bfe) begin
                bus_function_extension <= pwdata[15:0] & NSB_BFE_WR_MASK;
            end
            if (hit_swc) begin
                space_wait_control <= pwdata[12:0];
            end
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = !(psel && penable) ? 32'h0 :
                    hit_bfe ? {16'h0, bus_function_extension} :
                    hit_swc ? {19'h0, space_wait_control} :
                    hit_st ? status_word : 32'h0;

endmodule : nsb_ctrl

`default_nettype wire

// *** hdl/nsb_pkg.sv ***
// Package for the normal-space external bus controller: register map,
// field positions, reset values and the request carrier.
// Assumes a 32-bit APB register bus and an 8-bit external data bus.
package nsb_pkg;

    localparam logic [11:0] NSB_OFS_BUS_FUNC_EXT = 12'h000;
    localparam logic [11:0] NSB_OFS_SPACE_WAIT = 12'h004;
    localparam logic [11:0] NSB_OFS_STATUS = 12'h008;

    // bus_function_extension fields
    localparam int NSB_BFE_CPU_PRI_BIT = 9;
    localparam int NSB_BFE_ORDER_BIT = 8;
    localparam logic [15:0] NSB_BFE_WR_MASK = 16'h0300;
    localparam logic [15:0] NSB_BFE_RESET = 16'h0000;

    // space_wait_control fields
    localparam int NSB_SWC_RD_WAIT_LSB = 0;
    localparam int NSB_SWC_WR_WAIT_LSB = 4;
    localparam int NSB_SWC_WAIT_MASK_BIT = 8;
    localparam int NSB_SWC_SETUP_LSB = 9;
    localparam int NSB_SWC_HOLD_LSB = 11;
    localparam logic [12:0] NSB_SWC_RESET = 13'h0000;

    // Status fields
    localparam int NSB_ST_BUSY_BIT = 0;
    localparam int NSB_ST_TC_OWNER_BIT = 1;
    localparam int NSB_ST_STATE_LSB = 4;
    localparam int NSB_ST_PEND_LSB = 8;

    localparam logic [1:0] NSB_SIZE_BYTE = 2'h0;
    localparam logic [1:0] NSB_SIZE_WORD = 2'h1;
    localparam logic [1:0] NSB_SIZE_LONG = 2'h2;

    localparam logic [3:0] NSB_AGE_MAX = 4'hF;

    typedef struct packed {
        logic we;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } nsb_req_t;

    typedef enum logic [2:0] {
        NSB_IDLE,
        NSB_NOP,
        NSB_SETUP,
        NSB_FIRST,
        NSB_WAIT,
        NSB_FINAL,
        NSB_HOLD
    } nsb_state_t;

endpackage : nsb_pkg

// *** bench/nsb_ctrl_assertions.sv ***
// Port checker for the normal-space bus controller.
// Assumes one pclk domain and binding to nsb_ctrl.
`timescale 1ns/1ns
`default_nettype none
module nsb_ctrl_assertions
    import nsb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic low_write_strobe_n,
    input wire logic high_write_strobe_n,
    input wire logic data_oe,
    input wire logic info_skip_disable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic bfe_acc = psel && penable && paddr == NSB_OFS_BUS_FUNC_EXT;
    wire logic order_wr = pwdata[NSB_BFE_ORDER_BIT];
    sequence s_sel_two;
        !chip_select_n [*2];
    endsequence
    sequence s_rd_two;
        !read_strobe_n [*2];
    endsequence
    a_high_strobe_off: assert property (high_write_strobe_n)
        else $error("high write strobe asserted");
    a_strobes_apart: assert property (read_strobe_n || low_write_strobe_n)
        else $error("read and write strobes together");
    a_strobe_in_select: assert property (!read_strobe_n || !low_write_strobe_n |-> !chip_select_n)
        else $error("strobe outside chip select");
    a_select_two: assert property ($fell(chip_select_n) |-> s_sel_two)
        else $error("select shorter than two cycles");
    a_read_two: assert property ($fell(read_strobe_n) |-> s_rd_two)
        else $error("read strobe shorter than two cycles");
    a_write_drive: assert property (!low_write_strobe_n |-> data_oe)
        else $error("write data not driven under strobe");
    a_hold_drive: assert property ($rose(low_write_strobe_n) && !chip_select_n |-> data_oe)
        else $error("write data dropped in hold");
    a_reserved_zero: assert property (bfe_acc && !pwrite |-> prdata[7:0] == 8'h00)
        else $error("reserved bits read nonzero");
    a_skip_follow: assert property (bfe_acc && pwrite |=> info_skip_disable == $past(order_wr))
        else $error("skip disable does not follow order bit");
endmodule : nsb_ctrl_assertions
`default_nettype wire

// *** bench/nsb_sram_model.sv ***
// Byte-wide SRAM on the far side of the controller.
// Assumes 256 bytes; wait line held low for stall cycles per select.
`timescale 1ns/1ns
`default_nettype none
module nsb_sram_model (
    input wire logic clk,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] din,
    input wire logic [3:0] stall,
    output logic [7:0] dout,
    output logic wait_n
);
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    logic [3:0] cnt = 4'h0;
    // Released bus shows the inverse of the last byte, so a late sample fails
    assign dout = (!cs_n && !rd_n) ? mem[addr] : ~last;
    assign wait_n = cs_n || cnt == 4'h0;
    always @(posedge clk) begin
        if (!cs_n && !wr_n) mem[addr] <= din;
        if (!cs_n && !rd_n) last <= mem[addr];
        cnt <= cs_n ? stall : (cnt == 4'h0 ? cnt : cnt - 4'h1);
    end
endmodule : nsb_sram_model
`default_nettype wire

// *** bench/nsb_ctrl_bench.sv ***
// Self-checking bench for nsb_ctrl with an SRAM model.
// Assumes the controller answers APB at once and acks each access.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin failures++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module nsb_ctrl_bench;
    import nsb_pkg::*;
    typedef struct {nsb_req_t c; logic [12:0] swc; int n; logic [31:0] rd;} nsb_row_t;
    logic pclk, presetn, ce, psel, penable, pwrite, cpu_req, cpu_int_io, tc_req, tc_active, tc_ready;
    logic pready, pslverr, cpu_ack, tc_ack, act_start, info_skip_disable, data_oe, wait_n, e;
    logic chip_select_n, read_strobe_n, low_write_strobe_n, high_write_strobe_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, cpu_rdata, tc_rdata, ext_addr, r;
    logic [1:0] act_src;
    logic [3:0] act_req, stall;
    logic [7:0] data_out, data_in;
    nsb_req_t cpu_cmd, tc_cmd;
    int failures, checked, n;
    nsb_row_t rows [7] = '{
        '{'{1'b1, NSB_SIZE_LONG, 32'h10, 32'h11223344}, 13'h0100, 10, 32'h0},
        '{'{1'b0, NSB_SIZE_LONG, 32'h10, 32'h0}, 13'h0100, 10, 32'h11223344},
        '{'{1'b1, NSB_SIZE_WORD, 32'h20, 32'hA5C3}, 13'h0000, 7, 32'h0},
        '{'{1'b0, NSB_SIZE_WORD, 32'h20, 32'h0}, 13'h0003, 13, 32'hA5C3},
        '{'{1'b0, NSB_SIZE_BYTE, 32'h21, 32'h0}, 13'h1700, 9, 32'hC3},
        '{'{1'b1, NSB_SIZE_BYTE, 32'h30, 32'h5A}, 13'h0B50, 11, 32'h0},
        '{'{1'b0, NSB_SIZE_BYTE, 32'h30, 32'h0}, 13'h01F2, 6, 32'h5A}};
    nsb_ctrl dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req),
        .cpu_cmd(cpu_cmd), .cpu_int_io(cpu_int_io), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .tc_req(tc_req),
        .tc_cmd(tc_cmd), .tc_ack(tc_ack), .tc_rdata(tc_rdata), .act_req(act_req), .tc_active(tc_active),
        .tc_ready(tc_ready), .act_start(act_start), .act_src(act_src), .info_skip_disable(info_skip_disable),
        .ext_addr(ext_addr), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
        .low_write_strobe_n(low_write_strobe_n), .high_write_strobe_n(high_write_strobe_n),
        .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .wait_n(wait_n));
    nsb_sram_model mdl (.clk(pclk), .cs_n(chip_select_n), .rd_n(read_strobe_n), .wr_n(low_write_strobe_n),
        .addr(ext_addr[7:0]), .din(data_out), .stall(stall), .dout(data_in), .wait_n(wait_n));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (!pready);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic access(input bit tc, input nsb_req_t c);
        n = 0;
        @(posedge pclk);
        if (tc) begin
            tc_cmd <= c;
            tc_req <= 1'b1;
        end else begin
            cpu_cmd <= c;
            cpu_req <= 1'b1;
        end
        do begin
            @(posedge pclk);
            n++;
        end while (!(tc ? tc_ack : cpu_ack) && n < 200);
        r = tc ? tc_rdata : cpu_rdata;
        tc_req <= 1'b0;
        cpu_req <= 1'b0;
    endtask : access
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (6000) @(posedge pclk);
        failures++;
        test_done();
    end
    initial begin
        {psel, penable, pwrite, cpu_req, cpu_int_io, tc_req, tc_active, tc_ready} = '0;
        {paddr, pwdata, cpu_cmd, tc_cmd, act_req, stall} = '0;
        ce = 1'b1;
        failures = 0;
        checked = 0;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, NSB_OFS_SPACE_WAIT, 0);
        `CHK("swc reset", 32'h0, r)
        apb(1'b1, NSB_OFS_BUS_FUNC_EXT, 32'h3FF);
        apb(1'b0, NSB_OFS_BUS_FUNC_EXT, 0);
        `CHK("bfe read", 32'h300, r)
        `CHK("skip disable", 1'b1, info_skip_disable)
        apb(1'b0, 12'h00C, 0);
        `CHK("unmapped", 1'b1, e)
        $display("test registers done");
        foreach (rows[i]) begin
            apb(1'b1, NSB_OFS_SPACE_WAIT, {19'h0, rows[i].swc});
            access(i[0], rows[i].c);
            `CHK("cycles", rows[i].n, n)
            `CHK("rdata", rows[i].rd, r)
        end
        `CHK("msb at low address", 8'h11, mdl.mem[8'h10])
        $display("test rows done");
        // Priority and the idle slot after internal I/O, for both settings of bit 9
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, NSB_OFS_SPACE_WAIT, 32'h100);
            apb(1'b1, NSB_OFS_BUS_FUNC_EXT, p << 9);
            @(posedge pclk);
            cpu_int_io <= 1'b1;
            @(posedge pclk);
            cpu_int_io <= 1'b0;
            access(1'b0, rows[6].c);
            `CHK("nop cycles", p ? 4 : 5, n)
            @(posedge pclk);
            cpu_cmd <= rows[6].c;
            tc_cmd <= rows[6].c;
            cpu_req <= 1'b1;
            tc_req <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (!(cpu_ack || tc_ack) && n < 100);
            `CHK("cpu first", p[0], cpu_ack)
            cpu_req <= 1'b0;
            tc_req <= 1'b0;
            // Four software waits outlast the three-flop filter, so with bit 8 clear the pin is seen before the final cycle
            stall <= 4'h6;
            apb(1'b1, NSB_OFS_SPACE_WAIT, p ? 32'h104 : 32'h004);
            access(1'b0, rows[6].c);
            `CHK("wait stretch", p ? 8 : 14, n)
            `CHK("wait rdata", 32'h5A, r)
            stall <= 4'h0;
        end
        $display("test priority done");
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, NSB_OFS_BUS_FUNC_EXT, k == 1 ? 32'h100 : 32'h0);
            @(posedge pclk);
            tc_active <= (k == 2);
            act_req <= 4'h4;
            @(posedge pclk);
            act_req <= 4'h0;
            @(posedge pclk);
            act_req <= 4'h1;
            @(posedge pclk);
            act_req <= 4'h0;
            tc_ready <= 1'b1;
            n = 0;
            do @(posedge pclk); while (!act_start && ++n < 20);
            `CHK("first source", (k == 0) ? 2'h2 : 2'h0, act_src)
            do @(posedge pclk); while (!act_start && ++n < 40);
            `CHK("second source", (k == 0) ? 2'h0 : 2'h2, act_src)
            tc_ready <= 1'b0;
            tc_active <= 1'b0;
        end
        $display("test activation done");
        apb(1'b1, NSB_OFS_BUS_FUNC_EXT, 32'h300);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("skip after reset", 1'b0, info_skip_disable)
        apb(1'b0, NSB_OFS_BUS_FUNC_EXT, 0);
        `CHK("bfe after reset", 32'h0, r)
        $display("test reset done");
        test_done();
    end
endmodule : nsb_ctrl_bench
bind nsb_ctrl nsb_ctrl_assertions chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .low_write_strobe_n(low_write_strobe_n),
    .high_write_strobe_n(high_write_strobe_n), .data_oe(data_oe), .info_skip_disable(info_skip_disable));
`default_nettype wire
